// *** rtl/tic_timer.sv ***
// long interval timer: time-of-day chain, interval counter, sfr access
// Overview of operation
// - intervals from one 1/128 s tick up to 256 hours via timebase and count
// - all timekeeping advances from the 32.768 kHz crystal, not core clock
// - counters keep running while the device is powered down
// - interval counter steps on overflow of the selected time stage
// - count equal to target sets match flag bit 2, requests interrupt when TIC_IRQ_EN is set
// - match in power-down with interrupt enabled wakes to vector 0053H
// - time registers are writable to preset the current time
// - control register at A1H, resets to 00H, not bit addressable
// - timebase 00 fine tick, 01 seconds, 10 minutes, 11 hours
// - one-shot timeout clears interval enable, otherwise counter reloads
// - timekeeping disable stops counters, restores last written time values
// - fine count 0 to 127 into seconds, seconds 0 to 59 into minutes
`timescale 1ns/1ps
`default_nettype none
module tic_timer
    import tic_pkg::*;
#(
    parameter int PRESCALE = TIC_PRESCALE
) (
    input  wire logic        SYS_CLK,
    input  wire logic        RST_N,
    input  wire logic        XTAL_CLK,
    input  wire logic [7:0]  SFR_ADDR,
    input  wire logic        SFR_WR,
    input  wire logic        SFR_RD,
    input  wire logic [7:0]  SFR_WDATA,
    input  wire logic        PWR_DOWN,
    input  wire logic        TIC_IRQ_EN,
    output var  logic [7:0]  SFR_RDATA,
    output var  logic        TIC_IRQ,
    output var  logic        WAKE,
    output var  logic [15:0] WAKE_VECTOR
);

    localparam logic [7:0] PRE_TOP = 8'(PRESCALE - 1);

    if (PRESCALE < 1 || PRESCALE > 256) begin : g_chk
        $error("tic_timer prescale must be 1 to 256");
    end

    tic_ctrl_type  ctrl;
    tic_ctrl_type  next_ctrl;
    tic_carry_type carry;
    logic [7:0]    target;
    logic [7:0]    next_target;
    logic [7:0]    iv_count;
    logic [7:0]    next_iv_count;
    logic [7:0]    pre_count;
    logic [7:0]    next_pre_count;
    logic [2:0]    xtal_sync;
    logic          xtal_edge;
    logic          fine_tick;
    logic          iv_tick;
    logic          iv_hit;
    logic [TIC_FINE_W-1:0] fine_count;
    logic [TIC_SEC_W-1:0]  sec_count;
    logic [TIC_MIN_W-1:0]  min_count;
    logic [TIC_HOUR_W-1:0] hour_count;
    logic [7:0]    hour_top;
    logic          ctrl_wr;
    logic [7:0]    next_rdata;
    logic          next_irq;
    logic          next_wake;

    function automatic logic sel_overflow(tic_base_type b, tic_carry_type c);
        case (b)
            TIC_BASE_FINE: sel_overflow = c.fine;
            TIC_BASE_SEC:  sel_overflow = c.sec;
            TIC_BASE_MIN:  sel_overflow = c.min;
            TIC_BASE_HOUR: sel_overflow = c.hour;
            default:       sel_overflow = 1'b0;
        endcase
    endfunction : sel_overflow

    always_ff @(posedge SYS_CLK or negedge RST_N) begin
        if (!RST_N) begin
            xtal_sync <= 3'h0;
        end else begin
            xtal_sync <= {xtal_sync[1:0], XTAL_CLK};
        end
    end
    assign xtal_edge = xtal_sync[1] && !xtal_sync[2];

    // prescaler from crystal edges to the 1/128 s tick
    always_comb begin
        next_pre_count = pre_count;
        fine_tick      = ctrl.timekeeping_enable && xtal_edge
                         && (pre_count == PRE_TOP);
        if (!ctrl.timekeeping_enable) begin
            next_pre_count = 8'h00;
        end else if (xtal_edge) begin
            next_pre_count = fine_tick ? 8'h00 : 8'(pre_count + 8'h01);
        end
    end

    always_ff @(posedge SYS_CLK or negedge RST_N) begin
        if (!RST_N) begin
            pre_count <= 8'h00;
        end else begin
            pre_count <= next_pre_count;
        end
    end

    assign hour_top = ctrl.hour24 ? TIC_HOUR24_TOP : TIC_HOUR_TOP;
    // each stage's overflow is the tick of the next slower timebase
    assign carry.fine = fine_tick;

    tic_stage #(.W(TIC_FINE_W)) u_fine (
        .clk   (SYS_CLK),
        .rst_n (RST_N),
        .run   (ctrl.timekeeping_enable),
        .inc   (fine_tick),
        .wr    (SFR_WR && SFR_ADDR == TIC_ADDR_FINE),
        .wdata (SFR_WDATA[TIC_FINE_W-1:0]),
        .top   (TIC_FINE_TOP),
        .count (fine_count),
        .carry (carry.sec)
    );
    tic_stage #(.W(TIC_SEC_W)) u_sec (
        .clk   (SYS_CLK),
        .rst_n (RST_N),
        .run   (ctrl.timekeeping_enable),
        .inc   (carry.sec),
        .wr    (SFR_WR && SFR_ADDR == TIC_ADDR_SEC),
        .wdata (SFR_WDATA[TIC_SEC_W-1:0]),
        .top   (TIC_SEC_TOP),
        .count (sec_count),
        .carry (carry.min)
    );
    tic_stage #(.W(TIC_MIN_W)) u_min (
        .clk   (SYS_CLK),
        .rst_n (RST_N),
        .run   (ctrl.timekeeping_enable),
        .inc   (carry.min),
        .wr    (SFR_WR && SFR_ADDR == TIC_ADDR_MIN),
        .wdata (SFR_WDATA[TIC_MIN_W-1:0]),
        .top   (TIC_MIN_TOP),
        .count (min_count),
        .carry (carry.hour)
    );
    tic_stage #(.W(TIC_HOUR_W)) u_hour (
        .clk   (SYS_CLK),
        .rst_n (RST_N),
        .run   (ctrl.timekeeping_enable),
        .inc   (carry.hour),
        .wr    (SFR_WR && SFR_ADDR == TIC_ADDR_HOUR),
        .wdata (SFR_WDATA[TIC_HOUR_W-1:0]),
        .top   (hour_top),
        .count (hour_count),
        .carry ()
    );

    assign iv_tick = ctrl.interval_enable
                     && sel_overflow(ctrl.timebase, carry);
    assign iv_hit  = iv_tick && (8'(iv_count + 8'h01) == target);
    assign ctrl_wr = SFR_WR && (SFR_ADDR == TIC_ADDR_CONTROL);

    // control, target and interval counter
    always_comb begin
        next_ctrl     = ctrl;
        next_target   = target;
        next_iv_count = iv_count;
        if (ctrl_wr) begin
            next_ctrl          = tic_ctrl_type'(SFR_WDATA);
            next_ctrl.reserved = 1'b0;
        end
        if (SFR_WR && SFR_ADDR == TIC_ADDR_TARGET) begin
            next_target = SFR_WDATA;
        end
        if (!ctrl.interval_enable) begin
            next_iv_count = 8'h00;
        end else if (iv_hit) begin
            next_iv_count = 8'h00;
        end else if (iv_tick) begin
            next_iv_count = 8'(iv_count + 8'h01);
        end
        // match flag, set wins over clear
        if (iv_hit) begin
            next_ctrl.interval_match_flag = 1'b1;
        end
        if (iv_hit && ctrl.one_shot_select) begin
            next_ctrl.interval_enable = 1'b0;
        end
    end

    // no power-down gating of any counter
    always_ff @(posedge SYS_CLK or negedge RST_N) begin
        if (!RST_N) begin
            ctrl     <= tic_ctrl_type'(TIC_CONTROL_RESET);
            target   <= TIC_TARGET_RESET;
            iv_count <= 8'h00;
        end else begin
            ctrl     <= next_ctrl;
            target   <= next_target;
            iv_count <= next_iv_count;
        end
    end

    // read mux and interrupt outputs
    always_comb begin
        next_rdata = SFR_RDATA;
        if (SFR_RD) begin
            case (SFR_ADDR)
                TIC_ADDR_CONTROL: next_rdata = ctrl;
                TIC_ADDR_FINE:    next_rdata = {1'b0, fine_count};
                TIC_ADDR_SEC:     next_rdata = {2'b00, sec_count};
                TIC_ADDR_MIN:     next_rdata = {2'b00, min_count};
                TIC_ADDR_HOUR:    next_rdata = hour_count;
                TIC_ADDR_TARGET:  next_rdata = target;
                default:          next_rdata = TIC_READ_UNMAPPED;
            endcase
        end
        next_irq  = ctrl.interval_match_flag && TIC_IRQ_EN;
        next_wake = next_irq && PWR_DOWN;
    end

    always_ff @(posedge SYS_CLK or negedge RST_N) begin
        if (!RST_N) begin
            SFR_RDATA   <= TIC_READ_UNMAPPED;
            TIC_IRQ     <= 1'b0;
            WAKE        <= 1'b0;
            WAKE_VECTOR <= TIC_NO_VECTOR;
        end else begin
            SFR_RDATA   <= next_rdata;
            TIC_IRQ     <= next_irq;
            WAKE        <= next_wake;
            WAKE_VECTOR <= next_wake ? TIC_VECTOR : TIC_NO_VECTOR;
        end
    end

    default clocking cb @(posedge SYS_CLK);
    endclocking
    default disable iff (!RST_N);

    chk_match_sets: assert property (
        iv_hit |=> ctrl.interval_match_flag)
        else $error("match did not set the flag");
    chk_irq_follows: assert property (
        (ctrl.interval_match_flag && TIC_IRQ_EN) |=> TIC_IRQ)
        else $error("interrupt not requested after match");
    chk_wake_vector: assert property (
        (ctrl.interval_match_flag && TIC_IRQ_EN && PWR_DOWN)
        |=> WAKE && WAKE_VECTOR == TIC_VECTOR)
        else $error("no wake to the timer vector");
    chk_one_shot: assert property (
        (iv_hit && ctrl.one_shot_select) |=> !ctrl.interval_enable)
        else $error("one-shot timeout left interval enabled");
    chk_auto_reload: assert property (
        (iv_hit && !ctrl.one_shot_select && !ctrl_wr)
        |=> iv_count == 8'h00 && ctrl.interval_enable)
        else $error("interval counter did not reload");
    chk_iv_step: assert property (
        (ctrl.interval_enable && !iv_tick && !ctrl_wr) |=> $stable(iv_count))
        else $error("interval counter moved without overflow");
    chk_fine_range: assert property (
        fine_tick && fine_count == TIC_FINE_TOP
        |=> fine_count == '0 && sec_count != $past(sec_count))
        else $error("fine count roll-over did not reach seconds");
    chk_sec_range: assert property (
        sec_count <= TIC_SEC_TOP)
        else $error("seconds count out of range");
    chk_stop_hold: assert property (
        (!ctrl.timekeeping_enable && $past(ctrl.timekeeping_enable) == 1'b0
         && !(SFR_WR && SFR_ADDR == TIC_ADDR_FINE)) |=> $stable(fine_count))
        else $error("fine count moved while timekeeping stopped");
    chk_prescale: assert property (
        (ctrl.timekeeping_enable && !fine_tick
         && !(SFR_WR && SFR_ADDR == TIC_ADDR_FINE)) |=> $stable(fine_count))
        else $error("fine count moved without a crystal tick");

    cov_hit_one_shot: cover property (iv_hit && ctrl.one_shot_select);
    cov_hit_reload:   cover property (iv_hit && !ctrl.one_shot_select);
    cov_wake:         cover property (WAKE);
    cov_hour_base:    cover property (iv_tick
                                      && ctrl.timebase == TIC_BASE_HOUR);

endmodule : tic_timer
`default_nettype wire

// *** rtl/tic_pkg.sv ***
// constants and types shared by the long interval timer
package tic_pkg;

    // special-function register addresses
    localparam logic [7:0] TIC_ADDR_CONTROL = 8'ha1;
    localparam logic [7:0] TIC_ADDR_FINE    = 8'ha2;
    localparam logic [7:0] TIC_ADDR_SEC     = 8'ha3;
    localparam logic [7:0] TIC_ADDR_MIN     = 8'ha4;
    localparam logic [7:0] TIC_ADDR_HOUR    = 8'ha5;
    localparam logic [7:0] TIC_ADDR_TARGET  = 8'ha6;

    // reset values
    localparam logic [7:0] TIC_CONTROL_RESET = 8'h00;
    localparam logic [7:0] TIC_TARGET_RESET  = 8'h00;
    localparam logic [7:0] TIC_READ_UNMAPPED = 8'h00;

    // crystal and tick rates
    localparam int TIC_XTAL_HZ   = 32768;
    localparam int TIC_FINE_HZ   = 128;
    localparam int TIC_PRESCALE  = TIC_XTAL_HZ / TIC_FINE_HZ;

    // counter widths and wrap points
    localparam int TIC_FINE_W = 7;
    localparam int TIC_SEC_W  = 6;
    localparam int TIC_MIN_W  = 6;
    localparam int TIC_HOUR_W = 8;
    localparam logic [6:0] TIC_FINE_TOP   = 7'h7f;
    localparam logic [5:0] TIC_SEC_TOP    = 6'h3b;
    localparam logic [5:0] TIC_MIN_TOP    = 6'h3b;
    localparam logic [7:0] TIC_HOUR24_TOP = 8'h17;
    localparam logic [7:0] TIC_HOUR_TOP   = 8'hff;

    // interrupt service vector handed to the core on wake-up
    localparam logic [15:0] TIC_VECTOR = 16'h0053;
    localparam logic [15:0] TIC_NO_VECTOR = 16'h0000;

    typedef enum logic [1:0] {
        TIC_BASE_FINE = 2'b00,
        TIC_BASE_SEC  = 2'b01,
        TIC_BASE_MIN  = 2'b10,
        TIC_BASE_HOUR = 2'b11
    } tic_base_type;

    // control register layout, bit 7 down to bit 0
    typedef struct packed {
        logic         reserved;
        logic         hour24;
        tic_base_type timebase;
        logic         one_shot_select;
        logic         interval_match_flag;
        logic         interval_enable;
        logic         timekeeping_enable;
    } tic_ctrl_type;

    // one-cycle ticks at each interval timebase rate
    typedef struct packed {
        logic fine;
        logic sec;
        logic min;
        logic hour;
    } tic_carry_type;

endpackage : tic_pkg

// *** rtl/tic_stage.sv ***
// one wrapping time-of-day counter stage with its written shadow value
`timescale 1ns/1ps
`default_nettype none
module tic_stage
    import tic_pkg::*;
#(
    parameter int W = 8
) (
    input  wire logic         clk,
    input  wire logic         rst_n,
    input  wire logic         run,
    input  wire logic         inc,
    input  wire logic         wr,
    input  wire logic [W-1:0] wdata,
    input  wire logic [W-1:0] top,
    output var  logic [W-1:0] count,
    output var  logic         carry
);

    logic [W-1:0] shadow;
    logic [W-1:0] next_shadow;
    logic [W-1:0] next_count;

    if (W < 1 || W > 8) begin : g_chk
        $error("tic_stage width must be 1 to 8");
    end

    always_comb begin
        next_shadow = shadow;
        next_count  = count;
        carry       = run && inc && (count == top);
        if (wr) begin
            next_shadow = wdata;
            next_count  = wdata;
        end else if (!run) begin
            next_count = shadow;
        end else if (inc) begin
            next_count = (count == top) ? '0 : W'(count + 1'b1);
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            shadow <= '0;
            count  <= '0;
        end else begin
            shadow <= next_shadow;
            count  <= next_count;
        end
    end

endmodule : tic_stage
`default_nettype wire

// *** dv/tic_timer_test.sv ***
// self-checking bench for the long interval timer
`timescale 1ns/1ps
`default_nettype none
module tic_timer_test
    import tic_pkg::*;
();
    localparam int PS = 2;
    logic        sys_clk;
    logic        rst_n     = 1'b0;
    logic        xtal_clk  = 1'b0;
    logic [7:0]  sfr_addr  = 8'h00;
    logic        sfr_wr    = 1'b0;
    logic        sfr_rd    = 1'b0;
    logic [7:0]  sfr_wdata = 8'h00;
    logic        pwr_down  = 1'b0;
    logic        irq_en    = 1'b0;
    logic [7:0]  sfr_rdata;
    logic        tic_irq;
    logic        wake;
    logic [15:0] wake_vector;
    int          num_errors = 0;
    int          n_compared = 0;

    tic_timer #(.PRESCALE(PS)) dut_u (
        .SYS_CLK    (sys_clk),
        .RST_N      (rst_n),
        .XTAL_CLK   (xtal_clk),
        .SFR_ADDR   (sfr_addr),
        .SFR_WR     (sfr_wr),
        .SFR_RD     (sfr_rd),
        .SFR_WDATA  (sfr_wdata),
        .PWR_DOWN   (pwr_down),
        .TIC_IRQ_EN (irq_en),
        .SFR_RDATA  (sfr_rdata),
        .TIC_IRQ    (tic_irq),
        .WAKE       (wake),
        .WAKE_VECTOR(wake_vector)
    );

    initial begin
        sys_clk = 1'b0;
        forever #50 sys_clk = ~sys_clk;
    end

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        n_compared++;
        if (seen !== exp) begin
            num_errors++;
            $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic sfr_write(input logic [7:0] a, input logic [7:0] d);
        @(posedge sys_clk);
        sfr_addr  <= a;
        sfr_wdata <= d;
        sfr_wr    <= 1'b1;
        @(posedge sys_clk);
        sfr_wr <= 1'b0;
    endtask : sfr_write

    task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
        @(posedge sys_clk);
        sfr_addr <= a;
        sfr_rd   <= 1'b1;
        @(posedge sys_clk);
        sfr_rd <= 1'b0;
        @(negedge sys_clk);
        check({8'h00, sfr_rdata}, {8'h00, e});
    endtask : rd_chk

    // crystal edges spaced well apart for the three-flop sampler
    task automatic ticks(input int n);
        repeat (n * PS) begin
            @(posedge sys_clk);
            xtal_clk <= 1'b1;
            repeat (2) @(posedge sys_clk);
            xtal_clk <= 1'b0;
            @(posedge sys_clk);
        end
        repeat (6) @(posedge sys_clk);
    endtask : ticks

    task automatic test_done();
        $display("compared %0d, mismatches %0d", n_compared, num_errors);
        if (num_errors == 0 && n_compared > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : test_done

    initial begin
        repeat (50000) @(posedge sys_clk);
        num_errors++;
        test_done();
    end

    initial begin
        logic [1:0] tb;
        int         k;
        logic       hit;
        repeat (6) @(posedge sys_clk);
        rst_n <= 1'b1;
        for (int a = 'ha1; a <= 'ha6; a++) begin
            rd_chk(8'(a), 8'h00);
        end
        rd_chk(8'ha0, TIC_READ_UNMAPPED);
        sfr_write(TIC_ADDR_CONTROL, 8'h80);
        rd_chk(TIC_ADDR_CONTROL, TIC_CONTROL_RESET);
        $display("test reset done");

        sfr_write(TIC_ADDR_FINE, 8'h7e);
        sfr_write(TIC_ADDR_SEC, 8'h3b);
        sfr_write(TIC_ADDR_MIN, 8'h05);
        rd_chk(TIC_ADDR_FINE, 8'h7e);
        sfr_write(TIC_ADDR_CONTROL, 8'h01);
        ticks(2);
        rd_chk(TIC_ADDR_FINE, 8'h00);
        rd_chk(TIC_ADDR_SEC, 8'h00);
        rd_chk(TIC_ADDR_MIN, 8'h06);
        sfr_write(TIC_ADDR_CONTROL, 8'h00);
        rd_chk(TIC_ADDR_FINE, 8'h7e);
        rd_chk(TIC_ADDR_SEC, 8'h3b);
        rd_chk(TIC_ADDR_MIN, 8'h05);
        $display("test time of day done");

        @(posedge sys_clk);
        irq_en <= 1'b1;
        sfr_write(TIC_ADDR_TARGET, 8'h03);
        sfr_write(TIC_ADDR_CONTROL, 8'h03);
        ticks(2);
        rd_chk(TIC_ADDR_CONTROL, 8'h03);
        check(16'(tic_irq), 16'h0000);
        ticks(1);
        rd_chk(TIC_ADDR_CONTROL, 8'h07);
        check(16'(tic_irq), 16'h0001);
        check(16'(wake), 16'h0000);
        sfr_write(TIC_ADDR_CONTROL, 8'h03);
        repeat (2) @(negedge sys_clk);
        check(16'(tic_irq), 16'h0000);
        ticks(3);
        rd_chk(TIC_ADDR_CONTROL, 8'h07);
        sfr_write(TIC_ADDR_CONTROL, 8'h01);
        sfr_write(TIC_ADDR_CONTROL, 8'h0b);
        ticks(3);
        rd_chk(TIC_ADDR_CONTROL, 8'h0d);
        @(posedge sys_clk);
        irq_en <= 1'b0;
        repeat (2) @(negedge sys_clk);
        check(16'(tic_irq), 16'h0000);
        $display("test interval done");

        // step only when the selected stage overflows
        @(posedge sys_clk);
        irq_en <= 1'b1;
        for (int b = 0; b < 4; b++) begin
            for (int pos = (b == 0); pos < 2; pos++) begin
                tb  = 2'(b);
                k   = b - 1 + pos;
                hit = (pos == 1) && (b == 3);
                sfr_write(TIC_ADDR_CONTROL, 8'h00);
                sfr_write(TIC_ADDR_FINE, (k > 0) ? 8'h7f : 8'h00);
                sfr_write(TIC_ADDR_SEC, (k > 1) ? 8'h3b : 8'h00);
                sfr_write(TIC_ADDR_MIN, (k > 2) ? 8'h3b : 8'h00);
                sfr_write(TIC_ADDR_TARGET, 8'h01);
                pwr_down <= (b == 3);
                sfr_write(TIC_ADDR_CONTROL, {2'b00, tb, 4'h3});
                ticks(1);
                rd_chk(TIC_ADDR_CONTROL, {2'b00, tb, 1'b0, 1'(pos), 2'b11});
                check(16'(wake), 16'(hit));
                check(wake_vector, hit ? TIC_VECTOR : TIC_NO_VECTOR);
            end
        end
        @(posedge sys_clk);
        pwr_down <= 1'b0;
        $display("test timebase done");

        // target zero waits the full 256 steps
        sfr_write(TIC_ADDR_CONTROL, 8'h00);
        sfr_write(TIC_ADDR_TARGET, 8'h00);
        sfr_write(TIC_ADDR_CONTROL, 8'h03);
        ticks(255);
        rd_chk(TIC_ADDR_CONTROL, 8'h03);
        ticks(1);
        rd_chk(TIC_ADDR_CONTROL, 8'h07);
        $display("test long interval done");
        test_done();
    end
endmodule : tic_timer_test
`default_nettype wire
